// ---- occ_map.vh ----
`ifndef OCC_MAP_VH
`define OCC_MAP_VH
// Register indices (printed offsets are not all multiples of four)
`define OCC_IDX_SKEW        8'h1E
`define OCC_IDX_DRIVE       8'h1F
`define OCC_IDX_PAT_LOW     8'h20
`define OCC_IDX_PAT_MID     8'h21
`define OCC_IDX_PAT_HIGH    8'h22
`define OCC_IDX_FRAME_CTRL  8'h30
`define OCC_IDX_MODE_CTRL   8'h31
`define OCC_IDX_STATUS      8'h32
// Field positions
`define OCC_SKEW_LSB        4
`define OCC_DRV_REDUCED     7
`define OCC_DRV_CLKIN_EN    6
`define OCC_DRV_OB_EN       4
`define OCC_DRV_DOUBLE      3
`define OCC_SCR_LSB         6
`define OCC_FCTL_PIN_SEL    1
`define OCC_FCTL_CLKIN_EN   4
`define OCC_MODE_BYPASS     0
`define OCC_MODE_RES_LSB    1
// Reset values
`define OCC_RST_SKEW        8'h00
`define OCC_RST_DRIVE       8'h10
`define OCC_RST_PAT         8'h00
// Automatic frame patterns for bypass resolutions
`define OCC_PAT_AUTO_14     20'hFE000
`define OCC_PAT_AUTO_16     20'hFF000
`define OCC_PAT_AUTO_18     20'hFF800
// Timing: one skew step in picoseconds
`define OCC_SKEW_STEP_PS    50
`endif

// ---- occ_lfsr.v ----
`timescale 1ns/1ps
// Output data scrambler with two selectable polynomials
module occ_lfsr #(
  parameter WIDTH = 8
) (
  input  wire             pclk,
  input  wire             presetn,
  input  wire             step,
  input  wire [1:0]       mode,
  input  wire [WIDTH-1:0] data_in,
  output reg  [WIDTH-1:0] data_out
);
  reg  [14:0]      state_reg;
  wire             fb_a;
  wire             fb_b;
  wire             fb;
  wire [WIDTH-1:0] mask;

  assign fb_a = state_reg[14] ^ state_reg[13];
  assign fb_b = state_reg[14] ^ state_reg[0];
  assign fb   = mode[1] ? fb_b : fb_a;
  // Mask bit g is state bit g mod 15 XORed with the feedback bit
  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1)
    begin : g_mask
      assign mask[g] = state_reg[g % 15] ^ fb;
    end
  endgenerate

  // Advance state on each data step; pass data when disabled
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= 15'h7FFF;
      data_out  <= {WIDTH{1'b0}};
    end
    else if (step)
    begin
      state_reg <= {state_reg[13:0], fb};
      if (mode == 2'b01 || mode == 2'b10)
        data_out <= data_in ^ mask;
      else if (mode == 2'b11)
        data_out <= {data_in[WIDTH-1:1], ~data_in[0]}; // Fixed inversion of data bit 0
      else
        data_out <= data_in;
    end
  end
endmodule // occ_lfsr

// ---- occ_top.v ----
// Chosen here: register access over APB.
`timescale 1ns/1ps
`include "occ_map.vh"
// Behaviour
// - Two-bit skew code selects none, 50 ps advance, 50 or 100 ps delay.
// - Reduced-drive bit lowers output buffer drive strength; clear restores normal.
// - Serial input clock buffer powers only when both enable bits are set.
// - Output clock buffer on while bit 4 set; resets to one.
// - Double-rate bit: data launched on rising edge only; partner doubles input clock.
// - Double-rate bit clear: data launched on both output clock edges.
// - Frame clock formed from 20-bit pattern over three byte registers, low first.
// - In bypass the frame pattern follows the resolution, ignoring the programmed value.
// - Top bits 7-6 select no scramble, polynomial one, polynomial two, or inversion of data bit 0.
// - Pin select drives frame clock on a data pin, else parallel data.
module occ_top #(
  parameter DATA_W = 8
) (
  input  wire              pclk,
  input  wire              presetn,
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [11:0]       paddr,
  input  wire [31:0]       pwdata,
  output reg  [31:0]       prdata,
  output wire              pready,
  output wire              pslverr,
  input  wire              serial_input_clock,
  input  wire [DATA_W-1:0] sample_data,
  input  wire              sample_valid,
  output wire [1:0]        output_clock_skew,
  output wire              reduced_drive_sel,
  output wire              serial_clock_in_buffer_on,
  output wire              output_clock_buffer_on,
  output reg               output_bit_clock,
  output reg               serial_data,
  output reg               frame_clock,
  output reg  [DATA_W-1:0] parallel_data,
  output reg               frame_pin_out
);
  reg  [7:0]        skew_reg;
  reg  [7:0]        drive_reg;
  reg  [7:0]        pat_low_reg;
  reg  [7:0]        pat_mid_reg;
  reg  [7:0]        pat_high_reg;
  reg  [7:0]        frame_ctrl_reg;
  reg  [7:0]        mode_ctrl_reg;
  reg               clk_s1_reg;
  reg               clk_s2_reg;
  reg               clk_s3_reg;
  reg  [4:0]        pat_idx_reg;
  reg  [DATA_W-1:0] shift_reg;
  reg  [19:0]       pat_sel;
  reg  [31:0]       rd_next;
  wire [9:0]        idx;
  wire              acc;
  wire              wr;
  wire              mapped;
  wire              in_rise;
  wire              in_fall;
  wire              double_rate;
  wire              launch;
  wire [19:0]       pat_prog;
  wire [1:0]        scr_mode;
  wire [DATA_W-1:0] proc_data;
  reg               valid_q_reg;

  // APB access: zero-wait, index is byte address divided by four
  assign idx     = paddr[11:2];
  assign acc     = psel & penable;
  assign wr      = acc & pwrite;
  assign pready  = 1'b1;
  assign mapped  = (idx == {2'b00, `OCC_IDX_SKEW}) || (idx == {2'b00, `OCC_IDX_DRIVE}) ||
                   (idx == {2'b00, `OCC_IDX_PAT_LOW}) || (idx == {2'b00, `OCC_IDX_PAT_MID}) ||
                   (idx == {2'b00, `OCC_IDX_PAT_HIGH}) ||
                   (idx == {2'b00, `OCC_IDX_FRAME_CTRL}) ||
                   (idx == {2'b00, `OCC_IDX_MODE_CTRL}) || (idx == {2'b00, `OCC_IDX_STATUS});
  assign pslverr = acc & ~mapped;

  // Register writes; fields hold until rewritten or reset
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      skew_reg       <= `OCC_RST_SKEW;
      drive_reg      <= `OCC_RST_DRIVE; // Output clock buffer on at reset
      pat_low_reg    <= `OCC_RST_PAT;
      pat_mid_reg    <= `OCC_RST_PAT;
      pat_high_reg   <= `OCC_RST_PAT;
      frame_ctrl_reg <= 8'h00;
      mode_ctrl_reg  <= 8'h00;
    end
    else if (wr)
    begin
      if (idx == {2'b00, `OCC_IDX_SKEW})
        skew_reg <= pwdata[7:0];
      else if (idx == {2'b00, `OCC_IDX_DRIVE})
        drive_reg <= pwdata[7:0];
      else if (idx == {2'b00, `OCC_IDX_PAT_LOW})
        pat_low_reg <= pwdata[7:0];
      else if (idx == {2'b00, `OCC_IDX_PAT_MID})
        pat_mid_reg <= pwdata[7:0];
      else if (idx == {2'b00, `OCC_IDX_PAT_HIGH})
        pat_high_reg <= pwdata[7:0];
      else if (idx == {2'b00, `OCC_IDX_FRAME_CTRL})
        frame_ctrl_reg <= pwdata[7:0];
      else if (idx == {2'b00, `OCC_IDX_MODE_CTRL})
        mode_ctrl_reg <= pwdata[7:0];
    end
  end

  // Read mux, combinational from the current index
  always @*
  begin
    rd_next = 32'h00000000;
    if (idx == {2'b00, `OCC_IDX_SKEW})
      rd_next = {24'h000000, skew_reg};
    else if (idx == {2'b00, `OCC_IDX_DRIVE})
      rd_next = {24'h000000, drive_reg};
    else if (idx == {2'b00, `OCC_IDX_PAT_LOW})
      rd_next = {24'h000000, pat_low_reg};
    else if (idx == {2'b00, `OCC_IDX_PAT_MID})
      rd_next = {24'h000000, pat_mid_reg};
    else if (idx == {2'b00, `OCC_IDX_PAT_HIGH})
      rd_next = {24'h000000, pat_high_reg};
    else if (idx == {2'b00, `OCC_IDX_FRAME_CTRL})
      rd_next = {24'h000000, frame_ctrl_reg};
    else if (idx == {2'b00, `OCC_IDX_MODE_CTRL})
      rd_next = {24'h000000, mode_ctrl_reg};
    else if (idx == {2'b00, `OCC_IDX_STATUS})
      rd_next = {27'h0000000, pat_idx_reg};
  end

  // Read data comes straight from registers while in access phase
  always @*
  begin
    prdata = 32'h00000000;
    if (acc && !pwrite)
      prdata = rd_next;
  end

  // Static configuration outputs
  assign output_clock_skew         = skew_reg[`OCC_SKEW_LSB+1:`OCC_SKEW_LSB];
  assign reduced_drive_sel         = drive_reg[`OCC_DRV_REDUCED];
  assign serial_clock_in_buffer_on = drive_reg[`OCC_DRV_CLKIN_EN] &
                                     frame_ctrl_reg[`OCC_FCTL_CLKIN_EN];
  assign output_clock_buffer_on    = drive_reg[`OCC_DRV_OB_EN];
  assign double_rate               = drive_reg[`OCC_DRV_DOUBLE];
  assign pat_prog = {pat_high_reg[3:0], pat_mid_reg, pat_low_reg};
  assign scr_mode = pat_high_reg[`OCC_SCR_LSB+1:`OCC_SCR_LSB];

  // Frame pattern: automatic in bypass, programmed otherwise
  always @*
  begin
    pat_sel = pat_prog;
    if (mode_ctrl_reg[`OCC_MODE_BYPASS])
    begin
      case (mode_ctrl_reg[`OCC_MODE_RES_LSB+1:`OCC_MODE_RES_LSB])
        2'b00:   pat_sel = `OCC_PAT_AUTO_18;
        2'b01:   pat_sel = `OCC_PAT_AUTO_16;
        default: pat_sel = `OCC_PAT_AUTO_14;
      endcase
    end
  end

  // Two-stage synchroniser plus edge history for the input clock pin
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      clk_s1_reg <= 1'b0;
      clk_s2_reg <= 1'b0;
      clk_s3_reg <= 1'b0;
    end
    else
    begin
      clk_s1_reg <= serial_input_clock;
      clk_s2_reg <= clk_s1_reg;
      clk_s3_reg <= clk_s2_reg;
    end
  end

  assign in_rise = clk_s2_reg & ~clk_s3_reg;
  assign in_fall = ~clk_s2_reg & clk_s3_reg;
  // Double rate: every input rise is a launch on the output rise only
  // Normal: each input edge launches, output toggles per edge
  assign launch  = serial_clock_in_buffer_on & (in_rise | (~double_rate & in_fall));

  // Scrambler or encoder on each new word
  occ_lfsr #(
    .WIDTH (DATA_W)
  ) u_lfsr (
    .pclk     (pclk),
    .presetn  (presetn),
    .step     (sample_valid),
    .mode     (scr_mode),
    .data_in  (sample_data),
    .data_out (proc_data)
  );

  // Serialiser, output clock and frame clock generation
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      output_bit_clock <= 1'b0;
      serial_data      <= 1'b0;
      frame_clock      <= 1'b0;
      pat_idx_reg      <= 5'd0;
      shift_reg        <= {DATA_W{1'b0}};
    end
    else if (launch)
    begin
      if (double_rate)
        output_bit_clock <= 1'b1;           // Rising edge carries data
      else
        output_bit_clock <= ~output_bit_clock; // Both edges carry data
      serial_data <= shift_reg[DATA_W-1];
      if (pat_idx_reg == 5'd0)
        shift_reg <= proc_data;
      else
        shift_reg <= {shift_reg[DATA_W-2:0], 1'b0};
      frame_clock <= pat_sel[5'd19 - pat_idx_reg];
      if (pat_idx_reg == 5'd19)
        pat_idx_reg <= 5'd0;
      else
        pat_idx_reg <= pat_idx_reg + 5'd1;
    end
    else if (double_rate && in_fall)
      output_bit_clock <= 1'b0;
  end

  // Shared pin: frame clock or a parallel data bit
  // The processed word is ready one cycle after its valid pulse
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      valid_q_reg   <= 1'b0;
      parallel_data <= {DATA_W{1'b0}};
      frame_pin_out <= 1'b0;
    end
    else
    begin
      valid_q_reg <= sample_valid;
      if (valid_q_reg)
        parallel_data <= proc_data;
      if (frame_ctrl_reg[`OCC_FCTL_PIN_SEL])
        frame_pin_out <= frame_clock;
      else
        frame_pin_out <= parallel_data[0];
    end
  end
endmodule // occ_top

// ---- occ_monitor.sv ----
`timescale 1ns/1ps
// Watches control outputs and launch timing at the block pins
module occ_monitor (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire        pready,
  input wire [1:0]  output_clock_skew,
  input wire        reduced_drive_sel,
  input wire        serial_clock_in_buffer_on,
  input wire        output_clock_buffer_on,
  input wire        output_bit_clock,
  input wire        frame_clock,
  input wire        frame_pin_out
);
  wire       wr_hit = psel & penable & pwrite & pready;
  wire [9:0] idx    = paddr[11:2];
  reg  [7:0] skew_sh;
  reg  [7:0] drive_sh;
  reg  [7:0] fctl_sh;
  // Shadow copies of the control registers
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      skew_sh  <= 8'h00;
      drive_sh <= 8'h10;
      fctl_sh  <= 8'h00;
    end
    else if (wr_hit)
    begin
      if (idx == 10'h01E) skew_sh <= pwdata[7:0];
      if (idx == 10'h01F) drive_sh <= pwdata[7:0];
      if (idx == 10'h030) fctl_sh <= pwdata[7:0];
    end
  end
  default clocking dc @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_drive_wr;
    wr_hit && idx == 10'h01F;
  endsequence
  sequence s_gate_off;
    !serial_clock_in_buffer_on [*4];
  endsequence
  a_skew_code: assert property (output_clock_skew == skew_sh[5:4])
    else $error("skew output differs from register");
  a_low_drive: assert property (s_drive_wr |=> reduced_drive_sel == $past(pwdata[7]))
    else $error("reduced drive not taken from write");
  a_clock_buffer: assert property (output_clock_buffer_on == drive_sh[4])
    else $error("clock buffer enable wrong");
  a_clkin_both: assert property (
    serial_clock_in_buffer_on == (drive_sh[6] & fctl_sh[4]))
    else $error("input clock buffer enable wrong");
  a_launch_gated: assert property (s_gate_off |=> $stable(output_bit_clock))
    else $error("launch while input buffer off");
  a_both_edges: assert property (
    !drive_sh[3] && $changed(frame_clock) |-> $changed(output_bit_clock))
    else $error("frame step without clock edge");
  a_rise_only: assert property (
    drive_sh[3] && $changed(frame_clock) |-> $rose(output_bit_clock))
    else $error("double rate launch not on rise");
  a_frame_pin: assert property (
    fctl_sh[1] && $past(fctl_sh[1]) && $stable(frame_clock) |-> frame_pin_out == frame_clock)
    else $error("frame pin not carrying frame clock");
endmodule // occ_monitor

bind occ_top occ_monitor mon (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .output_clock_skew(output_clock_skew),
  .reduced_drive_sel(reduced_drive_sel), .output_clock_buffer_on(output_clock_buffer_on),
  .serial_clock_in_buffer_on(serial_clock_in_buffer_on), .frame_clock(frame_clock),
  .output_bit_clock(output_bit_clock), .frame_pin_out(frame_pin_out)
);

// ---- occ_capture.sv ----
`timescale 1ns/1ps
// Capture side: link clock in bursts, counts launches, records frame bits
module occ_capture (
  input  wire        pclk,
  input  wire        fast,
  input  wire        output_bit_clock,
  input  wire        frame_clock,
  output reg         serial_input_clock,
  output reg  [15:0] launches,
  output reg  [19:0] frame_bits
);
  reg obc_q;
  // Link clock rests low outside bursts
  initial
  begin
    serial_input_clock = 1'b0;
    launches = 16'h0000;
    frame_bits = 20'h00000;
    obc_q = 1'b0;
  end
  // Whole periods; doubled rate halves the period
  task burst(input integer n);
    repeat (2 * n) #(fast ? 20 : 40) serial_input_clock = ~serial_input_clock;
  endtask
  // Every clock edge is a launch, or only rises in doubled mode
  always @(posedge pclk)
  begin
    obc_q <= output_bit_clock;
    if (fast ? (output_bit_clock & ~obc_q) : (output_bit_clock ^ obc_q))
    begin
      launches   <= launches + 16'h0001;
      frame_bits <= {frame_bits[18:0], frame_clock};
    end
  end
endmodule // occ_capture

// ---- cmos_output_clock_config_tb.sv ----
`timescale 1ns/1ps
`include "occ_map.vh"
module cmos_output_clock_config_tb;
  reg         pclk, presetn, psel, penable, pwrite, sample_valid, fast, err_seen;
  reg  [11:0] paddr;
  reg  [31:0] pwdata, rd;
  reg  [7:0]  sample_data;
  reg  [15:0] base;
  wire [31:0] prdata;
  wire [19:0] frame_bits;
  wire [15:0] launches;
  wire [7:0]  parallel_data;
  wire [1:0]  output_clock_skew;
  wire        pready, pslverr, serial_input_clock, reduced_drive_sel, serial_data;
  wire        serial_clock_in_buffer_on, output_clock_buffer_on, output_bit_clock;
  wire        frame_clock, frame_pin_out;
  integer     errors, total_checks, k;

  occ_top #(.DATA_W(8)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_input_clock(serial_input_clock), .sample_data(sample_data),
    .sample_valid(sample_valid), .output_clock_skew(output_clock_skew),
    .reduced_drive_sel(reduced_drive_sel), .output_bit_clock(output_bit_clock),
    .serial_clock_in_buffer_on(serial_clock_in_buffer_on), .serial_data(serial_data),
    .output_clock_buffer_on(output_clock_buffer_on), .frame_clock(frame_clock),
    .parallel_data(parallel_data), .frame_pin_out(frame_pin_out)
  );
  occ_capture cap (
    .pclk(pclk), .fast(fast), .output_bit_clock(output_bit_clock), .frame_clock(frame_clock),
    .serial_input_clock(serial_input_clock), .launches(launches), .frame_bits(frame_bits)
  );
  // System clock
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task check(input string name, input [31:0] seen, input [31:0] exp);
    total_checks = total_checks + 1;
    if (seen !== exp)
    begin
      errors = errors + 1;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // One APB transfer: setup, access until pready, then release
  task apb(input wr, input [7:0] idx, input [31:0] wd);
    integer n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge pclk);
      n = n + 1;
    end
    check("apb ready", pready, 32'h1);
    rd = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask
  task rchk(input string name, input [7:0] idx, input [31:0] exp);
    apb(1'b0, idx, 32'h0);
    check(name, rd, exp);
  endtask
  function automatic [31:0] rot_hit(input [19:0] got, input [19:0] pat);
    integer i;
    rot_hit = 32'h0;
    for (i = 0; i < 20; i = i + 1)
      if (got === ((pat << i) | (pat >> (20 - i)))) rot_hit = 32'h1;
  endfunction
  // Runs n link periods, checks launch count and frame pattern order
  task link(input integer n, input [15:0] exp_n, input [19:0] pat);
    base = launches;
    cap.burst(n);
    repeat (10) @(posedge pclk);
    check("launches", launches - base, exp_n);
    if (exp_n != 0) check("frame pattern", rot_hit(frame_bits, pat), 32'h1);
  endtask
  task summarize;
    $display("Checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Watchdog
  initial
  begin
    #200000;
    errors = errors + 1;
    $display("Error watchdog expected finish seen timeout");
    summarize;
  end
  // Test sequence
  initial
  begin
    {presetn, psel, penable, pwrite, sample_valid, fast} = 6'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    sample_data = 8'h00;
    errors = 0;
    total_checks = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rchk("skew reset", `OCC_IDX_SKEW, 32'h00);
    rchk("drive reset", `OCC_IDX_DRIVE, 32'h10);
    check("buffer reset", output_clock_buffer_on, 32'h1);
    for (k = 0; k < 3; k = k + 1) rchk("pattern reset", 8'h20 + k, 32'h0);
    for (k = 0; k < 4; k = k + 1)
    begin
      apb(1'b1, `OCC_IDX_SKEW, k << 4);
      check("skew code", output_clock_skew, k);
      rchk("skew readback", `OCC_IDX_SKEW, k << 4);
    end
    $display("Test skew done");
    apb(1'b1, `OCC_IDX_DRIVE, 32'h80);
    check("low drive", reduced_drive_sel, 32'h1);
    check("clock buffer off", output_clock_buffer_on, 32'h0);
    apb(1'b1, `OCC_IDX_DRIVE, 32'h50);
    check("low drive off", reduced_drive_sel, 32'h0);
    check("in buffer half", serial_clock_in_buffer_on, 32'h0);
    link(4, 0, 20'h0);
    apb(1'b1, `OCC_IDX_FRAME_CTRL, 32'h12);
    check("in buffer on", serial_clock_in_buffer_on, 32'h1);
    apb(1'b1, `OCC_IDX_PAT_LOW, 32'h00);
    apb(1'b1, `OCC_IDX_PAT_MID, 32'hE0);
    apb(1'b1, `OCC_IDX_PAT_HIGH, 32'h0F);
    link(10, 20, 20'hFE000);
    check("frame on pin", frame_pin_out, frame_clock);
    apb(1'b1, `OCC_IDX_DRIVE, 32'h58);
    fast = 1'b1;
    link(20, 20, 20'hFE000);
    apb(1'b1, `OCC_IDX_DRIVE, 32'h50);
    fast = 1'b0;
    $display("Test launch done");
    for (k = 0; k < 3; k = k + 1)
    begin
      apb(1'b1, `OCC_IDX_MODE_CTRL, 1 | (k << 1));
      link(10, 20, k == 0 ? 20'hFF800 : (k == 1 ? 20'hFF000 : 20'hFE000));
    end
    apb(1'b1, `OCC_IDX_MODE_CTRL, 32'h00);
    $display("Test bypass done");
    for (k = 0; k < 4; k = k + 1)
    begin
      apb(1'b1, `OCC_IDX_PAT_HIGH, (k << 6) | 32'h0F);
      rchk("scramble code", `OCC_IDX_PAT_HIGH, (k << 6) | 32'h0F);
    end
    apb(1'b1, `OCC_IDX_PAT_HIGH, 32'h0F);
    apb(1'b1, `OCC_IDX_FRAME_CTRL, 32'h10);
    @(posedge pclk);
    sample_data <= 8'hA5;
    sample_valid <= 1'b1;
    @(posedge pclk);
    sample_valid <= 1'b0;
    repeat (3) @(posedge pclk);
    #1;
    check("plain data", parallel_data, 32'hA5);
    check("data on pin", frame_pin_out, 32'h1);
    apb(1'b0, 8'h40, 32'h0);
    check("unmapped error", err_seen, 32'h1);
    check("unmapped data", rd, 32'h0);
    $display("Test data done");
    summarize;
  end
endmodule // cmos_output_clock_config_tb
